/* File: fnd_pkg.sv */
// Package for the FSK noise detector and clock recovery loop filter.
// Assumes one 125 MHz core clock and 32-bit APB register access.
package fnd_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is the index times four)
  // ---------------------------------------------------------------
  localparam logic [9:0]  NOISE_CFG_IDX   = 10'h045;
  localparam logic [9:0]  PROP_CFG_IDX    = 10'h046;
  localparam logic [9:0]  INTEG_CFG_IDX   = 10'h047;
  localparam logic [9:0]  LOW_THR_IDX     = 10'h060;
  localparam logic [9:0]  STATUS_IDX      = 10'h061;
  localparam int          NUM_CFG         = 4;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  NOISE_CFG_RST   = 8'h07;
  localparam logic [7:0]  PROP_CFG_RST    = 8'hE6;
  localparam logic [7:0]  INTEG_CFG_RST   = 8'h65;
  localparam logic [7:0]  LOW_THR_RST     = 8'h00;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int          NOISE_RANGE_LSB = 6;
  localparam int          DET_SRC_LSB     = 4;
  localparam int          NOISE_THR_LSB   = 2;
  localparam int          NOISE_SLEW_LSB  = 0;
  localparam int          REC_SLEW_LSB    = 6;
  localparam int          OUTER_EN_BIT    = 5;
  localparam int          INNER_EN_BIT    = 4;
  localparam int          PROP_GAIN_LSB   = 2;
  localparam int          PROP_LIM_LSB    = 0;
  localparam int          EXTRAP_LSB      = 6;
  localparam int          IPATH_LIM_LSB   = 4;
  localparam int          INTEG_GAIN_LSB  = 2;
  localparam int          IACC_LIM_LSB    = 0;

  // ---------------------------------------------------------------
  // Detector source codes
  // ---------------------------------------------------------------
  localparam logic [1:0]  SRC_SQUELCH     = 2'h0;
  localparam logic [1:0]  SRC_NOISE       = 2'h1;
  localparam logic [1:0]  SRC_BOTH        = 2'h2;
  localparam logic [1:0]  SRC_QUALIFIED   = 2'h3;

  // ---------------------------------------------------------------
  // Number formats: phase in 1/16 bit in, 1/4096 bit inside
  // ---------------------------------------------------------------
  localparam int          PE_W            = 6;
  localparam int          FRAC_SHIFT      = 8;
  localparam int          LOOP_W          = 16;
  localparam int          SUM_W           = 22;
  localparam logic signed [LOOP_W-1:0] ONE_SIXTEENTH = 16'sh0100;
  localparam logic signed [PE_W-1:0]   OUTER_LIMIT   = 6'sd7;
  localparam logic signed [PE_W-1:0]   INNER_LIMIT   = 6'sd1;
  localparam int          PROP_LIM_BASE   = 0;
  localparam int          IPATH_LIM_BASE  = -1;
  localparam int          IACC_LIM_BASE   = 0;
  localparam int          INTEG_GAIN_BASE = 5;
  localparam int          EXTRAP_BASE     = 2;

  // ---------------------------------------------------------------
  // Noise detector scaling
  // ---------------------------------------------------------------
  localparam int          NOISE_RANGE_MAX = 7;
  localparam logic [15:0] THR_HALF        = 16'h4000;
  localparam logic [15:0] THR_3_8         = 16'h3000;
  localparam logic [15:0] THR_QUARTER     = 16'h2000;
  localparam logic [15:0] THR_EIGHTH      = 16'h1000;
  localparam int          NOISE_SLEW_BASE = 8;
  localparam int          PEAK_FRAC       = 8;

  typedef enum logic [1:0] {
    FND_IDLE  = 2'b00,
    FND_STARTUP_SEQUENCE = 2'b01,
    FND_TRACK = 2'b10
  } fnd_loop_e;

endpackage

/* File: fnd_peak.sv */
// Peak tracker with separate rise and fall slew shifts.
// Assumes samples arrive as unsigned magnitudes with a one-cycle strobe.
`timescale 1ns/100ps
`default_nettype none
module fnd_peak (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Sample in
  input  wire logic        valid,
  input  wire logic [7:0]  mag,
  input  wire logic [3:0]  up_shift,
  input  wire logic [3:0]  down_shift,
  // Peak out, integer part
  output logic      [7:0]  peak
);
  import fnd_pkg::*;

  logic [15:0] peak_q;
  logic [15:0] peak_d;
  logic [15:0] target;

  // Fractional state so slow rates still move the peak
  always_comb begin
    target = {mag, 8'h00};
    peak_d = peak_q;
    if (valid) begin
      if (target > peak_q) begin
        peak_d = peak_q + ((target - peak_q) >> up_shift);
      end else begin
        peak_d = peak_q - ((peak_q - target) >> down_shift);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      peak_q <= 16'h0000;
    end else begin
      peak_q <= peak_d;
    end
  end

  assign peak = peak_q[15:PEAK_FRAC];

  a_peak_bound: assert property (@(posedge clk) disable iff (!rst_b)
    valid && ({mag, 8'h00} >= peak_q) |=> peak_q <= $past({mag, 8'h00}))
    else $error("peak overshoots its input");

endmodule
`default_nettype wire

/* File: fnd_top.sv */
// FSK noise detector and PI loop filter of the clock recovery path.
// Assumes all inputs come from logic on CORE_CLK and an APB master.
`timescale 1ns/100ps
`default_nettype none

module fnd_top (
  // Clock and reset
  input  wire  logic                         CORE_CLK,
  input  wire  logic                         RST_B,
  // APB slave
  input  wire  logic                         PSEL,
  input  wire  logic                         PENABLE,
  input  wire  logic                         PWRITE,
  input  wire  logic [11:0]                  PADDR,
  input  wire  logic [31:0]                  PWDATA,
  output logic       [31:0]                  PRDATA,
  output logic                               PREADY,
  output logic                               PSLVERR,
  // Baseband from the receive chain
  input  wire  logic                         SAMPLE_VALID,
  input  wire  logic [7:0]                   SAMPLE_MAG,
  input  wire  logic [7:0]                   SIGNAL_LEVEL,
  input  wire  logic                         SQUELCH_OPEN,
  // Phase detector and run-in control
  input  wire  logic                         PHASE_VALID,
  input  wire  logic signed [fnd_pkg::PE_W-1:0] PHASE_ERROR,
  input  wire  logic                         STARTUP_BEGIN,
  input  wire  logic                         STARTUP_DONE,
  // Recovered timing and qualifier
  output logic signed [fnd_pkg::LOOP_W-1:0]  PHASE_CORR,
  output logic signed [fnd_pkg::LOOP_W-1:0]  SAMPLE_PHASE,
  output logic       [7:0]                   RECOVERY_PEAK,
  output logic                               SIGNAL_DETECT
);
  import fnd_pkg::*;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic signed [LOOP_W-1:0] clamp(
    input logic signed [SUM_W-1:0]  v,
    input logic signed [LOOP_W-1:0] lim);
    logic signed [SUM_W-1:0] l;
    l = SUM_W'(lim);
    if (v > l) begin
      clamp = lim;
    end else if (v < -l) begin
      clamp = -lim;
    end else begin
      clamp = v[LOOP_W-1:0];
    end
  endfunction

  // Limits are powers of two in 1/16 bit steps
  function automatic logic signed [LOOP_W-1:0] limit_of(
    input logic [1:0] code,
    input int         base);
    int sh;
    sh = int'(code) + base;
    if (sh < 0) begin
      limit_of = ONE_SIXTEENTH >>> 1;
    end else begin
      limit_of = ONE_SIXTEENTH <<< sh;
    end
  endfunction

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------
  logic [7:0]  cfg_q [NUM_CFG];
  logic [7:0]  cfg_d [NUM_CFG];
  logic [9:0]  reg_idx;
  logic        wr_en;
  logic        setup;
  logic [31:0] rdata_q, rdata_d;
  logic        err_q, err_d;
  logic [7:0]  status;
  logic [7:0]  noise_cfg, prop_cfg, integ_cfg, low_thr;

  localparam logic [7:0] CFG_RST [NUM_CFG] =
    '{NOISE_CFG_RST, PROP_CFG_RST, INTEG_CFG_RST, LOW_THR_RST};
  localparam logic [9:0] CFG_IDX [NUM_CFG] =
    '{NOISE_CFG_IDX, PROP_CFG_IDX, INTEG_CFG_IDX, LOW_THR_IDX};

  assign reg_idx   = PADDR[11:2];
  assign setup     = PSEL && !PENABLE;
  assign wr_en     = PSEL && PENABLE && PWRITE;
  assign noise_cfg = cfg_q[0];
  assign prop_cfg  = cfg_q[1];
  assign integ_cfg = cfg_q[2];
  assign low_thr   = cfg_q[3];
  assign PREADY    = 1'b1;
  assign PRDATA    = rdata_q;
  assign PSLVERR   = err_q && PSEL && PENABLE;

  // New values act on the next loop update, no shadowing needed
  always_comb begin
    for (int i = 0; i < NUM_CFG; i++) begin
      cfg_d[i] = cfg_q[i];
      if (wr_en && reg_idx == CFG_IDX[i] && PADDR[1:0] == 2'b00) begin
        cfg_d[i] = PWDATA[7:0];
      end
    end
  end

  // Read data is captured in the setup cycle for a zero-wait answer
  always_comb begin
    rdata_d = rdata_q;
    err_d   = err_q;
    if (setup) begin
      err_d   = 1'b0;
      rdata_d = 32'h0000_0000;
      if (PADDR[1:0] != 2'b00) begin
        err_d = 1'b1;
      end else begin
        case (reg_idx)
          NOISE_CFG_IDX: rdata_d = {24'h000000, noise_cfg};
          PROP_CFG_IDX:  rdata_d = {24'h000000, prop_cfg};
          INTEG_CFG_IDX: rdata_d = {24'h000000, integ_cfg};
          LOW_THR_IDX:   rdata_d = {24'h000000, low_thr};
          STATUS_IDX:    rdata_d = {24'h000000, status};
          default:       err_d   = 1'b1;
        endcase
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_CFG; g++) begin : g_cfg
      always_ff @(posedge CORE_CLK) begin
        if (!RST_B) begin
          cfg_q[g] <= CFG_RST[g];
        end else begin
          cfg_q[g] <= cfg_d[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      rdata_q <= 32'h0000_0000;
      err_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      err_q   <= err_d;
    end
  end

  // ---------------------------------------------------------------
  // Noise detector and qualifier
  // ---------------------------------------------------------------
  logic [7:0]  prev_mag_q, prev_mag_d;
  logic [7:0]  noise_mag;
  logic [7:0]  noise_peak;
  logic [15:0] noise_scaled;
  logic [15:0] noise_thr;
  logic        noise_ok;
  logic        low_ok;
  logic        det_q, det_d;
  logic [1:0]  det_src;
  logic [3:0]  nslew;
  logic [3:0]  rup, rdown;

  assign det_src = noise_cfg[DET_SRC_LSB +: 2];
  assign noise_mag = (SAMPLE_MAG > prev_mag_q) ? SAMPLE_MAG - prev_mag_q
                                               : prev_mag_q - SAMPLE_MAG;
  assign nslew = 4'(NOISE_SLEW_BASE) - {2'b00, noise_cfg[NOISE_SLEW_LSB +: 2]};

  always_comb begin
    case (prop_cfg[REC_SLEW_LSB +: 2])
      2'h0:    begin rup = 4'h6; rdown = 4'h6; end
      2'h1:    begin rup = 4'h6; rdown = 4'h7; end
      2'h2:    begin rup = 4'h5; rdown = 4'h7; end
      default: begin rup = 4'h5; rdown = 4'h8; end
    endcase
  end

  fnd_peak u_noise_peak (
    .clk        (CORE_CLK),
    .rst_b      (RST_B),
    .valid      (SAMPLE_VALID),
    .mag        (noise_mag),
    .up_shift   (nslew),
    .down_shift (nslew),
    .peak       (noise_peak)
  );

  fnd_peak u_recovery_peak (
    .clk        (CORE_CLK),
    .rst_b      (RST_B),
    .valid      (SAMPLE_VALID),
    .mag        (SAMPLE_MAG),
    .up_shift   (rup),
    .down_shift (rdown),
    .peak       (RECOVERY_PEAK)
  );

  always_comb begin
    noise_scaled = {8'h00, noise_peak} <<
                   (NOISE_RANGE_MAX - int'(noise_cfg[NOISE_RANGE_LSB +: 2]));
    case (noise_cfg[NOISE_THR_LSB +: 2])
      2'h0:    noise_thr = THR_HALF;
      2'h1:    noise_thr = THR_3_8;
      2'h2:    noise_thr = THR_QUARTER;
      default: noise_thr = THR_EIGHTH;
    endcase
  end

  assign noise_ok = noise_scaled < noise_thr;
  assign low_ok   = SIGNAL_LEVEL > low_thr;

  always_comb begin
    prev_mag_d = SAMPLE_VALID ? SAMPLE_MAG : prev_mag_q;
    case (det_src)
      SRC_SQUELCH:   det_d = SQUELCH_OPEN;
      SRC_NOISE:     det_d = noise_ok;
      SRC_BOTH:      det_d = SQUELCH_OPEN && noise_ok;
      SRC_QUALIFIED: det_d = SQUELCH_OPEN && noise_ok && low_ok;
      default:       det_d = 1'b0;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      prev_mag_q <= 8'h00;
      det_q      <= 1'b0;
    end else begin
      prev_mag_q <= prev_mag_d;
      det_q      <= det_d;
    end
  end

  assign SIGNAL_DETECT = det_q;

  // ---------------------------------------------------------------
  // Phase error blanking and PI loop filter
  // ---------------------------------------------------------------
  fnd_loop_e                state_q, state_d;
  logic signed [PE_W-1:0]   pe_abs;
  logic signed [PE_W-1:0]   pe_blank;
  logic signed [SUM_W-1:0]  pe_ext;
  logic signed [LOOP_W-1:0] p_path, i_path, i_acc_q, i_acc_d;
  logic signed [LOOP_W-1:0] corr_q, corr_d, phase_q, phase_d;
  logic signed [SUM_W-1:0]  rate_q, rate_d;
  logic signed [LOOP_W-1:0] iacc_lim;

  assign pe_abs   = PHASE_ERROR < 0 ? -PHASE_ERROR : PHASE_ERROR;
  assign iacc_lim = limit_of(integ_cfg[IACC_LIM_LSB +: 2], IACC_LIM_BASE);

  always_comb begin
    pe_blank = PHASE_ERROR;
    if (prop_cfg[OUTER_EN_BIT] && pe_abs > OUTER_LIMIT) begin
      pe_blank = '0;
    end
    if (prop_cfg[INNER_EN_BIT] && pe_abs < INNER_LIMIT) begin
      pe_blank = '0;
    end
    // Input is in 1/16 bit; extra fraction keeps small gains alive
    pe_ext = SUM_W'(pe_blank) <<< FRAC_SHIFT;
    p_path = clamp(pe_ext >>> prop_cfg[PROP_GAIN_LSB +: 2],
                   limit_of(prop_cfg[PROP_LIM_LSB +: 2], PROP_LIM_BASE));
    i_path = clamp(pe_ext >>> (INTEG_GAIN_BASE + int'(integ_cfg[INTEG_GAIN_LSB +: 2])),
                   limit_of(integ_cfg[IPATH_LIM_LSB +: 2], IPATH_LIM_BASE));
  end

  always_comb begin
    state_d = state_q;
    i_acc_d = i_acc_q;
    rate_d  = rate_q;
    corr_d  = corr_q;
    phase_d = phase_q;
    case (state_q)
      FND_IDLE: begin
        if (STARTUP_BEGIN) begin
          state_d = FND_STARTUP_SEQUENCE;
          rate_d  = '0;
        end
      end
      FND_STARTUP_SEQUENCE: begin
        if (PHASE_VALID) begin
          rate_d = rate_q + pe_ext;
        end
        if (STARTUP_DONE) begin
          // Run-in length is the start value time; short runs are noisy
          state_d = FND_TRACK;
          i_acc_d = clamp(rate_q >>> (EXTRAP_BASE + int'(integ_cfg[EXTRAP_LSB +: 2])),
                          iacc_lim);
        end
      end
      FND_TRACK: begin
        if (STARTUP_BEGIN) begin
          state_d = FND_STARTUP_SEQUENCE;
          rate_d  = '0;
        end
      end
      default: state_d = FND_IDLE;
    endcase
    if (PHASE_VALID && state_q == FND_TRACK) begin
      i_acc_d = clamp(SUM_W'(i_acc_q) + SUM_W'(i_path), iacc_lim);
    end
    if (PHASE_VALID) begin
      corr_d  = LOOP_W'(p_path + i_acc_q);
      phase_d = LOOP_W'(phase_q + p_path + i_acc_q);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      state_q <= FND_IDLE;
      i_acc_q <= '0;
      rate_q  <= '0;
      corr_q  <= '0;
      phase_q <= '0;
    end else begin
      state_q <= state_d;
      i_acc_q <= i_acc_d;
      rate_q  <= rate_d;
      corr_q  <= corr_d;
      phase_q <= phase_d;
    end
  end

  assign PHASE_CORR   = corr_q;
  assign SAMPLE_PHASE = phase_q;
  assign status = {3'b000, noise_ok, low_ok, det_q, state_q};

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  sequence s_startup_sequence_done;
    state_q == FND_STARTUP_SEQUENCE ##0 STARTUP_DONE;
  endsequence

  a_outer_blank: assert property (
    prop_cfg[OUTER_EN_BIT] && pe_abs > 6'sd7 |-> pe_blank == 0)
    else $error("outer error not blanked");
  a_inner_blank: assert property (
    prop_cfg[INNER_EN_BIT] && PHASE_ERROR == 0 |-> pe_blank == 0)
    else $error("inner error not blanked");
  a_prop_limit: assert property (
    p_path <= (16'sh0100 <<< prop_cfg[1:0]) && p_path >= -(16'sh0100 <<< prop_cfg[1:0]))
    else $error("proportional path over limit");
  // A narrower limit written mid-run only bites at the next update
  a_iacc_limit: assert property (
    PHASE_VALID && state_q == FND_TRACK |=>
      i_acc_q <= $past(iacc_lim) && i_acc_q >= -$past(iacc_lim))
    else $error("integral accumulator over limit");
  a_startup_sequence_load: assert property (
    s_startup_sequence_done |=> state_q == FND_TRACK && i_acc_q == $past(i_acc_d))
    else $error("run-in did not load integral path");
  a_corr_sum: assert property (
    PHASE_VALID |=> corr_q == LOOP_W'($past(p_path) + $past(i_acc_q)))
    else $error("correction is not p plus i");
  a_det_squelch: assert property (
    det_src == 2'h0 |=> SIGNAL_DETECT == $past(SQUELCH_OPEN))
    else $error("squelch mode detect wrong");
  a_det_qualify: assert property (
    det_src == 2'h3 && !low_ok |=> !SIGNAL_DETECT)
    else $error("detect valid below low threshold");
  a_cfg_write: assert property (
    wr_en && reg_idx == 10'h046 && PADDR[1:0] == 2'b00 |=> prop_cfg == $past(PWDATA[7:0]))
    else $error("config write lost");

endmodule
`default_nettype wire

/* File: fnd_bb_model.sv */
// Baseband sample source standing in for the receive chain.
// Assumes one clock shared with the block and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module fnd_bb_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Mode: steady tone or worst-case noise
  input  wire logic       noisy,
  // Sample out
  output logic            valid,
  output logic [7:0]      mag
);
  logic [1:0] cnt_q;
  logic [7:0] last_q;

  // One sample every four clocks. Between strobes the bus is inverted,
  // so the block cannot pass by reading a stale sample.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_q  <= 2'h0;
      last_q <= 8'h00;
      valid  <= 1'b0;
      mag    <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      valid <= (cnt_q == 2'h3);
      if (cnt_q == 2'h3) begin
        last_q <= noisy ? ~last_q : 8'hC8;
        mag    <= noisy ? ~last_q : 8'hC8;
      end else begin
        mag <= ~mag;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb_fnd_top.sv */
// Self-checking bench for the noise detector and recovery loop filter.
// Assumes zero-wait APB and loop outputs settled two clocks after a strobe.
`timescale 1ns/100ps
`default_nettype none
module tb_fnd_top;
  import fnd_pkg::*;
  localparam logic [11:0] A_N = {NOISE_CFG_IDX, 2'b00};
  localparam logic [11:0] A_P = {PROP_CFG_IDX, 2'b00};
  localparam logic [11:0] A_I = {INTEG_CFG_IDX, 2'b00};
  localparam logic [11:0] A_L = {LOW_THR_IDX, 2'b00};
  localparam logic [11:0] A_S = {STATUS_IDX, 2'b00};
  logic clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, sq = 0, pv = 0;
  logic sb = 0, sd = 0, noisy = 0, sv, se, prdy, perr, det_o;
  logic [11:0] paddr = 0;
  logic [31:0] pwd = 0, rd, prd;
  logic [7:0] lvl = 0, smag, rpeak;
  logic signed [5:0] pe = 0;
  logic signed [15:0] corr, sph;
  int err_total = 0, cmp_count = 0;
  always #4 clk = ~clk;
  fnd_bb_model bb (.clk(clk), .rst_b(rst_b), .noisy(noisy), .valid(sv), .mag(smag));
  fnd_top uut (.CORE_CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy),
    .PSLVERR(perr), .SAMPLE_VALID(sv), .SAMPLE_MAG(smag), .SIGNAL_LEVEL(lvl),
    .SQUELCH_OPEN(sq), .PHASE_VALID(pv), .PHASE_ERROR(pe), .STARTUP_BEGIN(sb),
    .STARTUP_DONE(sd), .PHASE_CORR(corr), .SAMPLE_PHASE(sph),
    .RECOVERY_PEAK(rpeak), .SIGNAL_DETECT(det_o));
  // ------------------------------------------------
  // Shared tasks
  // ------------------------------------------------
  task give_verdict;
    $display("errors %0d compares %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %0h got %0h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1; pen <= 0; pwr <= w; paddr <= a; pwd <= d;
    @(posedge clk);
    pen <= 1;
    for (n = 0; n < 16; n++) begin
      @(posedge clk);
      if (prdy === 1'b1) break;
    end
    if (n == 16) begin
      err_total++;
      give_verdict();
    end
    rd = prd;
    se = perr;
    psel <= 0; pen <= 0;
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk("rdata", e, rd);
  endtask
  // Update with one phase error; x of 99999 skips the check
  task upd(input logic signed [5:0] e, input int x);
    logic signed [15:0] ph_exp;
    ph_exp = sph + x[15:0];
    @(posedge clk); pv <= 1; pe <= e;
    @(posedge clk); pv <= 0;
    repeat (2) @(posedge clk);
    if (x != 99999) chk("corr", x, corr);
    if (x != 99999) chk("phase", ph_exp, sph);
  endtask
  task det(input logic e);
    repeat (4) @(posedge clk);
    chk("detect", e, det_o);
  endtask
  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  task t_reset;
    rdc(A_N, 32'h07);
    rdc(A_P, 32'hE6);
    rdc(A_I, 32'h65);
    rdc(A_L, 32'h00);
  endtask
  task t_regs;
    apb(1, A_P, 32'hFFFFFF5A);
    rdc(A_P, 32'h5A);
    apb(0, 12'h200, 0);
    chk("slverr", 1, se);
    chk("rdata", 0, rd);
  endtask
  task t_prop;
    int c, m;
    for (c = 0; c < 4; c++) begin
      apb(1, A_P, 32'hC3 | (c << 2));
      upd(4, 1024 >> c);
    end
    for (c = 0; c < 4; c++) begin
      apb(1, A_P, 32'hC0 | c);
      m = (256 << c) < 1792 ? (256 << c) : 1792;
      upd(7, m);
      upd(-7, -m);
    end
  endtask
  task t_blank;
    apb(1, A_P, 32'hE3);
    upd(8, 0);
    upd(-8, 0);
    upd(7, 1792);
    apb(1, A_P, 32'hC3);
    upd(8, 2048);
    apb(1, A_P, 32'hD3);
    upd(0, 0);
    upd(-1, -256);
  endtask
  task t_integ;
    apb(1, A_P, 32'hE6);
    apb(1, A_I, 32'h65);
    @(posedge clk); sb <= 1;
    @(posedge clk); sb <= 0;
    rdc(A_S, 32'h11);
    upd(4, 99999);
    upd(4, 99999);
    @(posedge clk); sd <= 1;
    @(posedge clk); sd <= 0;
    upd(0, 256);
    upd(4, 768);
    upd(0, 272);
    apb(1, A_I, 32'h60);
    repeat (6) upd(7, 99999);
    upd(0, 256);
    apb(1, A_P, 32'hC6);
    apb(1, A_I, 32'h43);
    upd(31, 1280);
    upd(0, 384);
  endtask
  task t_det;
    apb(1, A_N, 32'h07);
    sq <= 1;
    det(1);
    sq <= 0;
    det(0);
    apb(1, A_N, 32'h17);
    det(1);
    apb(1, A_N, 32'h27);
    sq <= 1;
    det(1);
    sq <= 0;
    det(0);
    apb(1, A_N, 32'h37);
    apb(1, A_L, 32'h80);
    sq <= 1; lvl <= 8'h10;
    det(0);
    lvl <= 8'h90;
    det(1);
    repeat (400) @(posedge clk);
    chk("peak", 1, rpeak > 8'hB0);
    noisy <= 1;
    apb(1, A_N, 32'h1F);
    repeat (400) @(posedge clk);
    det(0);
    apb(1, A_N, 32'hDF);
    det(1);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1;
    t_reset;
    t_regs;
    t_prop;
    t_blank;
    t_integ;
    t_det;
    give_verdict;
  end
endmodule
`default_nettype wire
